// file: bench/eight_channel_periph_dma_tb.sv
// Self-checking bench of the eight-channel DMA controller
`timescale 1ns/1ns
module eight_channel_periph_dma_tb;
   import epdma_pkg::*;
   logic         clk_i, rstn_i, wr_i, rd_i;
   logic [6:0]   addr_i;
   epdma_word_t  wdata_i;
   logic [15:0]  rdata_o, periph_index_i, p_addr_o, p_wdata_o, p_rdata_i;
   logic [15:0]  m_addr_o, m_wdata_o, m_rdata_i;
   logic [127:0] irq_i;
   logic         p_rd_o, p_wr_o, m_rd_o, m_wr_o;
   logic [1:0]   m_be_o;
   logic [7:0]   block_irq_o;
   logic [15:0]  rv;
   int           mismatches, num_checks;

   epdma_top u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_i(irq_i),
      .periph_index_i(periph_index_i), .p_addr_o(p_addr_o), .p_rd_o(p_rd_o),
      .p_wr_o(p_wr_o), .p_wdata_o(p_wdata_o), .p_rdata_i(p_rdata_i), .m_addr_o(m_addr_o),
      .m_rd_o(m_rd_o), .m_wr_o(m_wr_o), .m_be_o(m_be_o), .m_wdata_o(m_wdata_o),
      .m_rdata_i(m_rdata_i), .block_irq_o(block_irq_o));
   epdma_far_model u_far (.clk_i(clk_i), .rstn_i(rstn_i), .p_addr_i(p_addr_o),
      .p_rd_i(p_rd_o), .m_addr_i(m_addr_o), .m_rd_i(m_rd_o), .p_rdata_o(p_rdata_i),
      .m_rdata_o(m_rdata_i));

   // Clock, 4 ns period
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // Verdict and end of run
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Compare one value
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Register port cycles
   task automatic wreg(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      rv = rdata_o;
      chk(rv, exp);
   endtask

   // Addresses and count first, enable last, so no live channel is rewritten
   task automatic setch(input logic [2:0] c, input logic [15:0] con, req, pri, sec, pad, len);
      wreg({1'b0, c, 3'h2}, pri);
      wreg({1'b0, c, 3'h3}, sec);
      wreg({1'b0, c, 3'h4}, pad);
      wreg({1'b0, c, 3'h5}, len);
      wreg({1'b0, c, 3'h1}, req);
      wreg({1'b0, c, 3'h0}, con);
   endtask

   // One-cycle peripheral request
   task automatic pulse(input int n);
      @(posedge clk_i);
      irq_i[n] <= 1'b1;
      @(posedge clk_i);
      irq_i[n] <= 1'b0;
   endtask

   // Bounded wait for a write strobe; leaves the bench in that cycle
   task automatic xfer(input logic want);
      logic hit;
      logic rds;
      hit = 1'b0;
      rds = 1'b0;
      for (int i = 0; i < 16 && !hit; i++)
      begin
         @(negedge clk_i);
         rds = rds | m_rd_o | p_rd_o;
         hit = m_wr_o | p_wr_o;
      end
      chk({15'h0, hit}, {15'h0, want});
      chk({15'h0, rds}, {15'h0, want});
      if (want && !hit)
         finish_test();
   endtask

   // Reset values, field masks and unmapped places
   task automatic t_regs();
      rchk(7'h41, 16'h0f00);
      rchk(7'h38, 16'h0000);
      rchk(7'h06, 16'h0000);
      wreg(7'h38, 16'h7fff);
      rchk(7'h38, 16'h7833);
      wreg(7'h3d, 16'hffff);
      rchk(7'h3d, 16'h03ff);
      wreg(7'h3a, 16'hbeef);
      rchk(7'h3a, 16'hbeef);
      wreg(7'h3b, 16'h1234);
      rchk(7'h3b, 16'h1234);
      wreg(7'h39, 16'h007f);
      rchk(7'h39, 16'h007f);
   endtask

   // Word one-shot from peripheral with null write, two transfers
   task automatic t_oneshot();
      setch(3'h0, 16'h8801, 16'h0005, 16'h0100, 16'h0000, 16'h0020, 16'h0001);
      pulse(5);
      xfer(1'b1);
      chk(m_addr_o, 16'h0100);
      chk(m_wdata_o, 16'h0020 ^ 16'ha5c3);
      chk({14'h0, m_be_o}, 16'h0003);
      chk({15'h0, p_wr_o}, 16'h0001);
      chk(p_wdata_o, 16'h0000);
      chk({8'h0, block_irq_o}, 16'h0000);
      pulse(5);
      xfer(1'b1);
      chk(m_addr_o, 16'h0102);
      chk({8'h0, block_irq_o}, 16'h0001);
      pulse(5);
      xfer(1'b0);
      rchk(7'h00, 16'h0801);
      rchk(7'h41, 16'h0000);
   endtask

   // Forced byte from odd RAM address to peripheral
   task automatic t_force();
      setch(3'h2, 16'h6001, 16'h8000, 16'h0501, 16'h0000, 16'h0044, 16'h0000);
      rchk(7'h11, 16'h8000);
      wreg(7'h11, 16'h0000);
      rchk(7'h11, 16'h8000);
      wreg(7'h10, 16'he001);
      xfer(1'b1);
      chk(p_addr_o, 16'h0044);
      chk({8'h0, p_wdata_o[7:0]}, 16'h0039);
      chk({15'h0, m_wr_o}, 16'h0000);
      rchk(7'h11, 16'h0000);
      xfer(1'b0);
   endtask

   // Half-block pulse, continuous ping-pong, peripheral indirect
   task automatic t_modes();
      setch(3'h6, 16'h9001, 16'h0000, 16'h0800, 16'h0000, 16'h0000, 16'h0003);
      for (int i = 0; i < 4; i++)
      begin
         wreg(7'h31, 16'h8000);
         xfer(1'b1);
         chk({8'h0, block_irq_o}, (i == 1) ? 16'h0040 : 16'h0000);
      end
      setch(3'h3, 16'h8002, 16'h0000, 16'h0300, 16'h0400, 16'h0000, 16'h0000);
      for (int i = 0; i < 3; i++)
      begin
         wreg(7'h19, 16'h8000);
         xfer(1'b1);
         chk(m_addr_o, (i == 1) ? 16'h0400 : 16'h0300);
         chk({8'h0, block_irq_o}, 16'h0008);
      end
      wreg(7'h18, 16'h0000);
      setch(3'h1, 16'h8020, 16'h8000, 16'h0200, 16'h0000, 16'h0000, 16'h0000);
      xfer(1'b1);
      chk(m_addr_o, 16'h0206);
      rchk(7'h08, 16'h8020);
      wreg(7'h08, 16'h0000);
   endtask

   // Two channels on one request: lower one first, one-shot ping-pong stops
   task automatic t_prio();
      setch(3'h4, 16'h8001, 16'h0009, 16'h0600, 16'h0000, 16'h0000, 16'h0000);
      setch(3'h5, 16'h8003, 16'h0009, 16'h0700, 16'h0780, 16'h0000, 16'h0000);
      pulse(9);
      xfer(1'b1);
      chk(m_addr_o, 16'h0600);
      xfer(1'b1);
      chk(m_addr_o, 16'h0700);
      rchk(7'h41, 16'h0528);
      chk({12'h0, rv[11:8]}, 16'h0005);
      rchk(7'h28, 16'h8003);
      pulse(9);
      xfer(1'b1);
      chk(m_addr_o, 16'h0780);
      rchk(7'h28, 16'h0003);
   endtask

   // Main sequence
   initial
   begin
      mismatches = 0;
      num_checks = 0;
      rstn_i = 1'b0;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 7'h00;
      wdata_i = 16'h0000;
      irq_i = '0;
      periph_index_i = 16'h0006;
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_regs();
      t_oneshot();
      t_force();
      t_modes();
      t_prio();
      finish_test();
   end
endmodule

// file: bench/epdma_far_model.sv
// Peripheral registers and DMA RAM answering the transfer bus
`timescale 1ns/1ns
module epdma_far_model
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   // Read strobes and addresses
   input  wire logic [15:0] p_addr_i,
   input  wire logic        p_rd_i,
   input  wire logic [15:0] m_addr_i,
   input  wire logic        m_rd_i,
   // Read data, valid one cycle after the strobe
   output logic      [15:0] p_rdata_o,
   output logic      [15:0] m_rdata_o
);
   // Data is a pattern of the address; outside the data cycle it toggles,
   // so a late sample never sees stale data that looks right
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         p_rdata_o <= 16'h0000;
         m_rdata_o <= 16'h0000;
      end
      else
      begin
         p_rdata_o <= p_rd_i ? (p_addr_i ^ 16'ha5c3) : ~p_rdata_o;
         m_rdata_o <= m_rd_i ? (m_addr_i ^ 16'h3c96) : ~m_rdata_o;
      end
   end
endmodule

// file: verilog/epdma_map.svh
// Register offsets, field positions and reset values of the eight-channel DMA
`ifndef EPDMA_MAP_SVH
`define EPDMA_MAP_SVH
`define EPDMA_NCH        8
`define EPDMA_OFF_CON    3'h0
`define EPDMA_OFF_REQ    3'h1
`define EPDMA_OFF_PRI    3'h2
`define EPDMA_OFF_SEC    3'h3
`define EPDMA_OFF_PAD    3'h4
`define EPDMA_OFF_LEN    3'h5
`define EPDMA_OFF_COLL   7'h40
`define EPDMA_OFF_STAT   7'h41
`define EPDMA_CON_ON     15
`define EPDMA_CON_BYTE   14
`define EPDMA_CON_DIR    13
`define EPDMA_CON_HALF   12
`define EPDMA_CON_NULL   11
`define EPDMA_CON_AM_HI  5
`define EPDMA_CON_AM_LO  4
`define EPDMA_CON_MD_HI  1
`define EPDMA_CON_MD_LO  0
`define EPDMA_CON_MASK   16'hf833
`define EPDMA_REQ_FORCE  15
`define EPDMA_REQ_NUM_HI 6
`define EPDMA_AM_POSTINC 2'h0
`define EPDMA_AM_PERIND  2'h2
`define EPDMA_MD_ONESHOT 2'h1
`define EPDMA_MD_OS_PP   2'h3
`define EPDMA_LAST_RST   4'hf
`define EPDMA_LEN_W      10
`endif

// file: verilog/epdma_pkg.sv
// Types of the eight-channel DMA controller
package epdma_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WT, ST_WR} epdma_st_e;
   typedef logic [15:0] epdma_word_t;
   typedef struct packed {
      epdma_st_e              st;
      logic [2:0]             ch;
      logic [7:0][15:0]       con;
      logic [7:0][15:0]       req;
      logic [7:0][15:0]       pri;
      logic [7:0][15:0]       sec;
      logic [7:0][15:0]       pad;
      logic [7:0][15:0]       cur;
      logic [7:0][9:0]        blen;
      logic [7:0][9:0]        done;
      logic [7:0]             pend;
      logic [7:0]             sel;
      logic [3:0]             last;
      epdma_word_t            rdata;
      epdma_word_t            p_addr;
      epdma_word_t            p_wdata;
      epdma_word_t            m_addr;
      epdma_word_t            m_wdata;
      logic                   p_rd;
      logic                   p_wr;
      logic                   m_rd;
      logic                   m_wr;
      logic [1:0]             m_be;
      logic [7:0]             irq;
   } epdma_state_s;
endpackage

// file: verilog/epdma_top.sv
// Eight-channel peripheral DMA controller with its own transfer bus
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "epdma_map.svh"
module epdma_top
(
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rstn_i,
   // Register port
   input  wire logic [6:0]           addr_i,
   input  wire epdma_pkg::epdma_word_t wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic [15:0]               rdata_o,
   // Peripheral requests
   input  wire logic [127:0]         irq_i,
   input  wire logic [15:0]          periph_index_i,
   // Peripheral side of the transfer bus
   output logic [15:0]               p_addr_o,
   output logic                      p_rd_o,
   output logic                      p_wr_o,
   output logic [15:0]               p_wdata_o,
   input  wire logic [15:0]          p_rdata_i,
   // DMA RAM port
   output logic [15:0]               m_addr_o,
   output logic                      m_rd_o,
   output logic                      m_wr_o,
   output logic [1:0]                m_be_o,
   output logic [15:0]               m_wdata_o,
   input  wire logic [15:0]          m_rdata_i,
   // Per-channel block interrupt requests
   output logic [7:0]                block_irq_o
);
   import epdma_pkg::*;

   epdma_state_s s;
   epdma_state_s next_s;
   logic [7:0]   reqv;
   logic [2:0]   win;
   logic         blk_end;

   // Lowest-numbered requester wins
   function automatic logic [2:0] lowest(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--)
      begin
         if (v[i])
         begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   // A channel asks for service when on and pending or forced
   for (genvar g = 0; g < `EPDMA_NCH; g++)
   begin : g_req
      assign reqv[g] = s.con[g][`EPDMA_CON_ON] &
                       (s.pend[g] | s.req[g][`EPDMA_REQ_FORCE]);
   end

   assign win     = lowest(reqv);
   assign blk_end = (s.done[s.ch] == s.blen[s.ch]);

   // Next-state logic for the whole controller
   always_comb
   begin
      logic [2:0]  k;
      logic [2:0]  c;
      logic [15:0] start;
      logic [15:0] data;
      logic [10:0] hp;
      logic [1:0]  md;
      logic [1:0]  am;
      logic        byt;
      logic        ns;
      k      = addr_i[5:3];
      c      = s.ch;
      start  = s.sel[c] ? s.sec[c] : s.pri[c];
      data   = 16'h0;
      hp     = (11'({1'b0, s.blen[c]}) + 11'h001) >> 1;
      md     = s.con[c][`EPDMA_CON_MD_HI:`EPDMA_CON_MD_LO];
      am     = s.con[c][`EPDMA_CON_AM_HI:`EPDMA_CON_AM_LO];
      byt    = s.con[c][`EPDMA_CON_BYTE];
      ns     = s.sel[c];
      next_s = s;
      // Strobes and read data last one cycle only
      next_s.rdata = 16'h0;
      next_s.p_rd  = 1'b0;
      next_s.p_wr  = 1'b0;
      next_s.m_rd  = 1'b0;
      next_s.m_wr  = 1'b0;
      next_s.irq   = 8'h0;

      // Transfer sequencer: one transfer at a time on the private bus
      case (s.st)
         ST_IDLE:
         begin
            if (|reqv)
            begin
               next_s.ch       = win;
               next_s.pend[win] = 1'b0;
               next_s.st       = ST_RD;
               start = s.sel[win] ? s.sec[win] : s.pri[win];
               if (s.con[win][`EPDMA_CON_AM_HI:`EPDMA_CON_AM_LO] == `EPDMA_AM_PERIND)
               begin
                  next_s.m_addr = start + periph_index_i;
               end
               else
               begin
                  next_s.m_addr = s.cur[win];
               end
               next_s.p_addr = s.pad[win];
               if (s.con[win][`EPDMA_CON_DIR])
               begin
                  next_s.m_rd = 1'b1;
               end
               else
               begin
                  next_s.p_rd = 1'b1;
               end
            end
         end
         ST_RD:
         begin
            next_s.st = ST_WT;
         end
         ST_WT:
         begin
            // Read data is on the bus now; launch the write
            if (s.con[c][`EPDMA_CON_DIR])
            begin
               data = m_rdata_i;
               if (byt)
               begin
                  data = {8'h00, s.m_addr[0] ? m_rdata_i[15:8] : m_rdata_i[7:0]};
               end
               next_s.p_wr    = 1'b1;
               next_s.p_wdata = data;
            end
            else
            begin
               next_s.m_wr    = 1'b1;
               next_s.m_wdata = byt ? {2{p_rdata_i[7:0]}} : p_rdata_i;
               next_s.m_be    = byt ? (s.m_addr[0] ? 2'b10 : 2'b01) : 2'b11;
               if (s.con[c][`EPDMA_CON_NULL])
               begin
                  next_s.p_wr    = 1'b1;
                  next_s.p_wdata = 16'h0;
               end
            end
            next_s.last = {1'b0, c};
            next_s.req[c][`EPDMA_REQ_FORCE] = 1'b0;
            if (am == `EPDMA_AM_POSTINC)
            begin
               next_s.cur[c] = s.cur[c] + (byt ? 16'h0001 : 16'h0002);
            end
            next_s.done[c] = s.done[c] + 10'h001;
            if (s.con[c][`EPDMA_CON_HALF] && hp != 11'h0 &&
                11'({1'b0, s.done[c]}) + 11'h001 == hp)
            begin
               next_s.irq[c] = 1'b1;
            end
            if (blk_end)
            begin
               // Block done: reload, maybe swap buffer, maybe stop
               next_s.done[c] = 10'h0;
               if (!s.con[c][`EPDMA_CON_HALF] || hp == 11'h0)
               begin
                  next_s.irq[c] = 1'b1;
               end
               if (md[1])
               begin
                  ns = ~s.sel[c];
               end
               next_s.sel[c] = ns;
               next_s.cur[c] = ns ? s.sec[c] : s.pri[c];
               if (md == `EPDMA_MD_ONESHOT || (md == `EPDMA_MD_OS_PP && s.sel[c]))
               begin
                  next_s.con[c][`EPDMA_CON_ON] = 1'b0;
               end
            end
            next_s.st = ST_WR;
         end
         ST_WR:
         begin
            next_s.st = ST_IDLE;
         end
         default:
         begin
            next_s.st = ST_IDLE;
         end
      endcase

      // Register writes come after hardware updates so software wins,
      // except the force bit, which software may only set
      if (wr_i && !addr_i[6])
      begin
         case (addr_i[2:0])
            `EPDMA_OFF_CON:
            begin
               next_s.con[k] = wdata_i & `EPDMA_CON_MASK;
               if (wdata_i[`EPDMA_CON_ON] && !s.con[k][`EPDMA_CON_ON])
               begin
                  next_s.cur[k]  = s.pri[k];
                  next_s.done[k] = 10'h0;
                  next_s.sel[k]  = 1'b0;
                  next_s.pend[k] = 1'b0;
               end
            end
            `EPDMA_OFF_REQ:
            begin
               next_s.req[k] = {next_s.req[k][`EPDMA_REQ_FORCE] | wdata_i[15],
                                8'h00, wdata_i[6:0]};
            end
            `EPDMA_OFF_PRI: next_s.pri[k] = wdata_i;
            `EPDMA_OFF_SEC: next_s.sec[k] = wdata_i;
            `EPDMA_OFF_PAD: next_s.pad[k] = wdata_i;
            `EPDMA_OFF_LEN: next_s.blen[k] = wdata_i[`EPDMA_LEN_W-1:0];
            default: ;
         endcase
      end

      // Register reads, answered in the next cycle; holes read zero
      if (rd_i)
      begin
         if (addr_i == `EPDMA_OFF_STAT)
         begin
            next_s.rdata = {4'h0, s.last, s.sel};
         end
         else if (!addr_i[6])
         begin
            case (addr_i[2:0])
               `EPDMA_OFF_CON: next_s.rdata = s.con[k];
               `EPDMA_OFF_REQ: next_s.rdata = s.req[k];
               `EPDMA_OFF_PRI: next_s.rdata = s.pri[k];
               `EPDMA_OFF_SEC: next_s.rdata = s.sec[k];
               `EPDMA_OFF_PAD: next_s.rdata = s.pad[k];
               `EPDMA_OFF_LEN: next_s.rdata = {6'h00, s.blen[k]};
               default:        next_s.rdata = 16'h0;
            endcase
         end
      end

      // Selected request sets pending; a set beats the grant clear
      for (int i = 0; i < `EPDMA_NCH; i++)
      begin
         if (next_s.con[i][`EPDMA_CON_ON] && irq_i[s.req[i][`EPDMA_REQ_NUM_HI:0]])
         begin
            next_s.pend[i] = 1'b1;
         end
      end
   end

   // Single state register, synchronous active-low reset
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         s      <= '0;
         s.st   <= ST_IDLE;
         s.last <= `EPDMA_LAST_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Every output comes straight from the state register
   assign rdata_o     = s.rdata;
   assign p_addr_o    = s.p_addr;
   assign p_rd_o      = s.p_rd;
   assign p_wr_o      = s.p_wr;
   assign p_wdata_o   = s.p_wdata;
   assign m_addr_o    = s.m_addr;
   assign m_rd_o      = s.m_rd;
   assign m_wr_o      = s.m_wr;
   assign m_be_o      = s.m_be;
   assign m_wdata_o   = s.m_wdata;
   assign block_irq_o = s.irq;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // Checks on the design's own behaviour
   a_read_idle_zero: assert property (!rd_i |=> rdata_o == 16'h0)
      else $error("read data not zero without read");
   a_last_channel: assert property (s.st == ST_WT |=> s.last == {1'b0, $past(s.ch)})
      else $error("last channel not recorded");
   a_rd_then_wr: assert property ((m_rd_o | p_rd_o) |=> !(m_rd_o | p_rd_o)
                                  ##1 (m_wr_o | p_wr_o))
      else $error("transfer sequence broken");
   a_dir_select: assert property (s.st == ST_RD |->
                                  m_rd_o == s.con[s.ch][`EPDMA_CON_DIR] &&
                                  p_rd_o == !s.con[s.ch][`EPDMA_CON_DIR])
      else $error("wrong read side for direction");
   a_dir_ram_wr: assert property (m_wr_o |-> !s.con[s.ch][`EPDMA_CON_DIR])
      else $error("RAM written in RAM-to-peripheral direction");
   a_byte_lane: assert property (m_wr_o |-> (m_be_o == 2'b11) ==
                                 !s.con[s.ch][`EPDMA_CON_BYTE])
      else $error("byte enables disagree with size");
   a_null_write: assert property (m_wr_o && s.con[s.ch][`EPDMA_CON_NULL] |->
                                  p_wr_o && p_wdata_o == 16'h0)
      else $error("null write missing beside RAM write");
   a_grant_lowest: assert property (s.st == ST_IDLE && |reqv |=>
                                    ($past(reqv) & ((8'h01 << s.ch) - 8'h01)) == 8'h0)
      else $error("lower channel skipped");
   a_single_xfer: assert property (!((m_rd_o | p_rd_o) && (m_wr_o | p_wr_o)))
      else $error("two transfers overlap");
   a_one_shot_stop: assert property (s.st == ST_WT && blk_end &&
                                     s.con[s.ch][1:0] == `EPDMA_MD_ONESHOT && !wr_i |=>
                                     !s.con[$past(s.ch)][`EPDMA_CON_ON])
      else $error("one-shot channel kept running");
   a_incr_word: assert property (s.st == ST_WT && !blk_end && !wr_i &&
                                 s.con[s.ch][5:4] == `EPDMA_AM_POSTINC &&
                                 !s.con[s.ch][`EPDMA_CON_BYTE] |=>
                                 s.cur[s.ch] == $past(s.cur[s.ch]) + 16'h0002)
      else $error("word post-increment wrong");
   a_force_hold: assert property (s.req[0][15] && !(s.st == ST_WT && s.ch == 3'h0) |=>
                                  s.req[0][15])
      else $error("force bit cleared early");

   // Transfer-end and block-end checks; a register write in the same cycle is left out
   // because software wins over hardware there
   a_force_clear: assert property (s.st == ST_WT && s.req[s.ch][15] && !wr_i |=>
                                   !s.req[s.ch][15])
      else $error("force bit not cleared after transfer");
   a_reload_start: assert property (s.st == ST_WT && blk_end && !wr_i |=>
                                    s.cur[s.ch] == (s.sel[s.ch] ? s.sec[s.ch] : s.pri[s.ch]))
      else $error("start address not reloaded at block end");
   a_ping_pong: assert property (s.st == ST_WT && blk_end && !wr_i &&
                                 s.con[s.ch][`EPDMA_CON_MD_HI] |=>
                                 s.sel[s.ch] != $past(s.sel[s.ch]))
      else $error("ping-pong buffer not swapped");
   a_irq_single: assert property ($onehot0(block_irq_o))
      else $error("more than one block interrupt at once");
   a_last_legal: assert property (s.last == `EPDMA_LAST_RST || !s.last[3])
      else $error("last channel value out of range");
   c_ram_to_periph: cover property (m_rd_o ##2 p_wr_o);
   c_null_write: cover property (m_wr_o && p_wr_o);
   c_block_irq: cover property (|block_irq_o);
   c_ping_pong: cover property ($rose(s.sel[3]));
   c_force_done: cover property ($fell(s.req[2][15]));
endmodule
